/* File: hdl/socfg_top.sv */
`timescale 1ns/1ps
// Operation
// - Port format 0 off, 1 continuous, 2 printer, 3 host.
// - Baud codes 0..6 give 1200 to 57600 baud.
// - Handshake 0 none, 1 XON/XOFF; port two also 2 hardware.
// - Port two hardware handshake forbids port three RS232C.
// - Address 1..99; zero means no addressing.
// - Frame 0 8N, 1 7-odd, 2 7-even.
// - Checksum 0 omits check byte, 1 appends it.
// - Port three format 4/5 Modbus RTU high-low or low-high word order.
// - Port three physical 0 RS232C, 1 RS485, 2 current loop.
// - Network format 0..3 as serial, 4/5 Modbus TCP word orders.
// - Network continuous output never appends check byte.
// - Non-continuous formats on at most one interface.
// - Layout 1 single, 2 multi, 3 template, 4 totalizing.
// - One-bit options include date/time and record number.
// - Identifier fields 0 omit, 1 code, 2 text, 3 both.
// - No printing below minimum weight.
// - Trigger 1 auto print when stable above minimum, rearm below; 0 key.
// - Trigger 2 refuses reprint until weight changes.
// - Top and bottom line feeds 0..9, optional page advance.
// - Copies 1..9, effective only for multi-line layout.
// - Exit: save to nonvolatile, keep until power-down, or discard.
// - One start and one stop bit per character.
module socfg_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [23:0] weight,
    input wire logic weight_stable,
    input wire logic print_key,
    output logic print_req,
    output logic nv_write,
    output socfg_pkg::socfg_line_t line1,
    output socfg_pkg::socfg_line_t line2,
    output socfg_pkg::socfg_line_t line3,
    output socfg_pkg::socfg_line_t line_net,
    output logic [1:0] phy3,
    output logic mb_low_first,
    output logic [3:0] copies_eff,
    output logic [3:0] frame_start_bits,
    output logic [3:0] frame_stop_bits
);
    socfg_pkg::socfg_port_t work [4];
    socfg_pkg::socfg_port_t live [4];
    socfg_pkg::socfg_prn_t prn_work;
    socfg_pkg::socfg_prn_t prn_live;
    logic [23:0] min_work;
    logic [23:0] min_live;
    logic [7:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic w_held;
    logic wr_err;
    logic [31:0] rej_count;
    logic armed;
    logic [23:0] last_weight;
    logic printed_once;

    // Checks a port setting; index selects which codes each port takes
    function automatic logic port_ok(input socfg_pkg::socfg_port_t c, input int idx,
                                     input socfg_pkg::socfg_port_t p2,
                                     input socfg_pkg::socfg_port_t others [4]);
        logic ok;
        ok = 1'b1;
        if (idx == 2 || idx == 3) begin
            if (c.fmt > socfg_pkg::FMT_MB_LH) ok = 1'b0;
        end else if (c.fmt > socfg_pkg::FMT_HOST) begin
            ok = 1'b0;
        end
        if (c.baud > socfg_pkg::BAUD_MAX) ok = 1'b0;
        if (c.hs > ((idx == 1) ? socfg_pkg::HS_HW : socfg_pkg::HS_XON)) ok = 1'b0;
        if (c.addr > socfg_pkg::ADDR_MAX) ok = 1'b0;
        if (c.frame > socfg_pkg::FRM_7E) ok = 1'b0;
        if (idx == 2) begin
            if (c.phy > socfg_pkg::PHY_CL) ok = 1'b0;
            if (c.phy == socfg_pkg::PHY_232 && p2.hs == socfg_pkg::HS_HW) ok = 1'b0;
        end
        if (idx == 1 && c.hs == socfg_pkg::HS_HW && others[2].phy == socfg_pkg::PHY_232) begin
            ok = 1'b0;
        end
        if (c.fmt != socfg_pkg::FMT_OFF && c.fmt != socfg_pkg::FMT_CONT) begin
            for (int k = 0; k < 4; k++) begin
                if (k != idx && others[k].fmt == c.fmt) ok = 1'b0;
            end
        end
        return ok;
    endfunction : port_ok

    function automatic logic prn_ok(input socfg_pkg::socfg_prn_t c);
        logic ok;
        ok = 1'b1;
        if (c.layout < socfg_pkg::LAY_MIN || c.layout > socfg_pkg::LAY_MAX) ok = 1'b0;
        if (c.trig > socfg_pkg::TRG_LOCK) ok = 1'b0;
        if (c.lf_top > socfg_pkg::DIGIT_MAX || c.lf_bot > socfg_pkg::DIGIT_MAX) ok = 1'b0;
        if (c.copies < socfg_pkg::COPY_MIN || c.copies > socfg_pkg::DIGIT_MAX) ok = 1'b0;
        return ok;
    endfunction : prn_ok

    wire logic do_write = aw_held && w_held && !s_axi_bvalid;
    wire logic [1:0] exit_code = w_data[1:0];
    socfg_pkg::socfg_port_t wcfg;
    assign wcfg = socfg_pkg::socfg_port_t'(w_data[21:0]);
    socfg_pkg::socfg_prn_t wprn;
    assign wprn = socfg_pkg::socfg_prn_t'(w_data[23:0]);

    logic write_ok;
    always_comb begin
        write_ok = 1'b0;
        unique case (aw_addr)
            socfg_pkg::OFS_IF1: write_ok = port_ok(wcfg, 0, work[1], work);
            socfg_pkg::OFS_IF2: write_ok = port_ok(wcfg, 1, work[1], work);
            socfg_pkg::OFS_IF3: write_ok = port_ok(wcfg, 2, work[1], work);
            socfg_pkg::OFS_NET: write_ok = port_ok(wcfg, 3, work[1], work);
            socfg_pkg::OFS_PRN: write_ok = prn_ok(wprn);
            socfg_pkg::OFS_MINW: write_ok = 1'b1;
            socfg_pkg::OFS_CTRL: write_ok = (exit_code != 2'h0);
            default: write_ok = 1'b0;
        endcase
    end

    // Write address and data are held separately so either may arrive first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= write_ok ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;

    // Working copy is edited; live copy drives the ports and changes only on exit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int k = 0; k < 4; k++) begin
                work[k] <= '0;
                live[k] <= '0;
            end
            prn_work <= '{layout: socfg_pkg::LAY_MIN, copies: socfg_pkg::COPY_MIN, default: '0};
            prn_live <= '{layout: socfg_pkg::LAY_MIN, copies: socfg_pkg::COPY_MIN, default: '0};
            min_work <= 24'h000000;
            min_live <= 24'h000000;
            nv_write <= 1'b0;
            wr_err <= 1'b0;
        end else begin
            nv_write <= 1'b0;
            if (do_write) begin
                wr_err <= !write_ok;
            end
            if (do_write && write_ok) begin
                unique case (aw_addr)
                    socfg_pkg::OFS_IF1: work[0] <= wcfg;
                    socfg_pkg::OFS_IF2: work[1] <= wcfg;
                    socfg_pkg::OFS_IF3: work[2] <= wcfg;
                    socfg_pkg::OFS_NET: work[3] <= wcfg;
                    socfg_pkg::OFS_PRN: prn_work <= wprn;
                    socfg_pkg::OFS_MINW: min_work <= w_data[23:0];
                    socfg_pkg::OFS_CTRL: begin
                        if (exit_code == socfg_pkg::EXIT_ABORT) begin
                            work <= live;
                            prn_work <= prn_live;
                            min_work <= min_live;
                        end else begin
                            live <= work;
                            prn_live <= prn_work;
                            min_live <= min_work;
                            nv_write <= (exit_code == socfg_pkg::EXIT_SAVE);
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rej_count <= 32'h0000_0000;
        end else if (do_write && !write_ok) begin
            rej_count <= rej_count + 32'h0000_0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            unique case ({s_axi_araddr[7:2], 2'b00})
                socfg_pkg::OFS_IF1: s_axi_rdata <= 32'(work[0]);
                socfg_pkg::OFS_IF2: s_axi_rdata <= 32'(work[1]);
                socfg_pkg::OFS_IF3: s_axi_rdata <= 32'(work[2]);
                socfg_pkg::OFS_NET: s_axi_rdata <= 32'(work[3]);
                socfg_pkg::OFS_PRN: s_axi_rdata <= 32'(prn_work);
                socfg_pkg::OFS_MINW: s_axi_rdata <= {8'h00, min_work};
                socfg_pkg::OFS_CTRL: s_axi_rdata <= {31'h0, wr_err};
                socfg_pkg::OFS_STAT: s_axi_rdata <= rej_count;
                socfg_pkg::OFS_WGT: s_axi_rdata <= {6'h00, armed, printed_once, weight};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    assign s_axi_arready = !s_axi_rvalid;

    wire logic above_min = weight >= min_live;
    wire logic moved = weight != last_weight;

    // Print trigger; auto mode rearms only after the load drops below minimum
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            print_req <= 1'b0;
            armed <= 1'b1;
            last_weight <= 24'h000000;
            printed_once <= 1'b0;
        end else begin
            print_req <= 1'b0;
            if (!above_min) armed <= 1'b1;
            if (above_min && !print_req) begin
                unique case (prn_live.trig)
                    socfg_pkg::TRG_AUTO: begin
                        if (armed && weight_stable && weight != min_live) begin
                            print_req <= 1'b1;
                            armed <= 1'b0;
                        end
                    end
                    socfg_pkg::TRG_LOCK: begin
                        if (print_key && (!printed_once || moved)) begin
                            print_req <= 1'b1;
                            printed_once <= 1'b1;
                            last_weight <= weight;
                        end
                    end
                    default: begin
                        if (print_key) print_req <= 1'b1;
                    end
                endcase
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_line
            socfg_pkg::socfg_line_t lo;
            socfg_line u_line (
                .aclk(aclk),
                .aresetn(aresetn),
                .cfg(live[g]),
                .is_net(g == 3),
                .line(lo)
            );
        end
    endgenerate
    assign line1 = g_line[0].lo;
    assign line2 = g_line[1].lo;
    assign line3 = g_line[2].lo;
    assign line_net = g_line[3].lo;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phy3 <= socfg_pkg::PHY_485;
            mb_low_first <= 1'b0;
            copies_eff <= socfg_pkg::COPY_MIN;
            frame_start_bits <= socfg_pkg::START_BITS;
            frame_stop_bits <= socfg_pkg::STOP_BITS;
        end else begin
            phy3 <= live[2].phy;
            mb_low_first <= (live[2].fmt == socfg_pkg::FMT_MB_LH) ||
                            (live[3].fmt == socfg_pkg::FMT_MB_LH);
            copies_eff <= (prn_live.layout == socfg_pkg::LAY_MULTI) ? prn_live.copies
                          : socfg_pkg::COPY_MIN;
            frame_start_bits <= socfg_pkg::START_BITS;
            frame_stop_bits <= socfg_pkg::STOP_BITS;
        end
    end

    property p_phy_not_232;
        @(posedge aclk) disable iff (!aresetn)
        (live[1].hs == socfg_pkg::HS_HW) |-> (live[2].phy != socfg_pkg::PHY_232);
    endproperty
    a_phy_not_232: assert property (p_phy_not_232) else $error("RS232C with hw handshake");

    property p_no_print_low;
        @(posedge aclk) disable iff (!aresetn)
        print_req |-> $past(above_min);
    endproperty
    a_no_print_low: assert property (p_no_print_low) else $error("print below minimum");

    property p_reject_keeps;
        @(posedge aclk) disable iff (!aresetn)
        (do_write && !write_ok) |=> $stable(live[0]) && s_axi_bresp == 2'h2;
    endproperty
    a_reject_keeps: assert property (p_reject_keeps) else $error("rejected write took effect");

    property p_auto_once;
        @(posedge aclk) disable iff (!aresetn)
        (print_req && prn_live.trig == socfg_pkg::TRG_AUTO) |-> !armed;
    endproperty
    a_auto_once: assert property (p_auto_once) else $error("auto print not disarmed");

    property p_copies;
        @(posedge aclk) disable iff (!aresetn)
        (prn_live.layout != socfg_pkg::LAY_MULTI) [*2] |-> copies_eff == socfg_pkg::COPY_MIN;
    endproperty
    a_copies: assert property (p_copies) else $error("copies outside multi-line");

    property p_net_csum;
        @(posedge aclk) disable iff (!aresetn)
        (live[3].fmt == socfg_pkg::FMT_CONT) [*2] |-> !line_net.check_byte;
    endproperty
    a_net_csum: assert property (p_net_csum) else $error("net continuous check byte");

    property p_lock_change;
        @(posedge aclk) disable iff (!aresetn)
        (print_req && prn_live.trig == socfg_pkg::TRG_LOCK) |-> $past(moved) || !$past(printed_once);
    endproperty
    a_lock_change: assert property (p_lock_change) else $error("interlock reprint");

    property p_exit_nv;
        @(posedge aclk) disable iff (!aresetn)
        nv_write |-> $past(aw_addr) == socfg_pkg::OFS_CTRL && $past(exit_code) == socfg_pkg::EXIT_SAVE;
    endproperty
    a_exit_nv: assert property (p_exit_nv) else $error("nv write without save");

endmodule : socfg_top

/* File: hdl/socfg_pkg.sv */
package socfg_pkg;

    localparam int CLK_HZ = 250_000_000;
    localparam int BAUD_COUNT = 7;
    localparam int BAUD_W = 20;

    localparam logic [7:0] OFS_IF1 = 8'h00;
    localparam logic [7:0] OFS_IF2 = 8'h04;
    localparam logic [7:0] OFS_IF3 = 8'h08;
    localparam logic [7:0] OFS_NET = 8'h0c;
    localparam logic [7:0] OFS_PRN = 8'h10;
    localparam logic [7:0] OFS_MINW = 8'h14;
    localparam logic [7:0] OFS_CTRL = 8'h18;
    localparam logic [7:0] OFS_STAT = 8'h1c;
    localparam logic [7:0] OFS_WGT = 8'h20;

    localparam logic [2:0] FMT_OFF = 3'h0;
    localparam logic [2:0] FMT_CONT = 3'h1;
    localparam logic [2:0] FMT_PRINT = 3'h2;
    localparam logic [2:0] FMT_HOST = 3'h3;
    localparam logic [2:0] FMT_MB_HL = 3'h4;
    localparam logic [2:0] FMT_MB_LH = 3'h5;

    localparam logic [2:0] BAUD_MAX = 3'h6;
    localparam logic [1:0] HS_NONE = 2'h0;
    localparam logic [1:0] HS_XON = 2'h1;
    localparam logic [1:0] HS_HW = 2'h2;
    localparam logic [6:0] ADDR_MAX = 7'h63;
    localparam logic [1:0] FRM_8N = 2'h0;
    localparam logic [1:0] FRM_7O = 2'h1;
    localparam logic [1:0] FRM_7E = 2'h2;
    localparam logic [1:0] PHY_232 = 2'h0;
    localparam logic [1:0] PHY_485 = 2'h1;
    localparam logic [1:0] PHY_CL = 2'h2;
    localparam logic [2:0] LAY_MIN = 3'h1;
    localparam logic [2:0] LAY_MULTI = 3'h2;
    localparam logic [2:0] LAY_MAX = 3'h4;
    localparam logic [1:0] TRG_KEY = 2'h0;
    localparam logic [1:0] TRG_AUTO = 2'h1;
    localparam logic [1:0] TRG_LOCK = 2'h2;
    localparam logic [3:0] DIGIT_MAX = 4'h9;
    localparam logic [3:0] COPY_MIN = 4'h1;
    localparam logic [1:0] EXIT_SAVE = 2'h1;
    localparam logic [1:0] EXIT_KEEP = 2'h2;
    localparam logic [1:0] EXIT_ABORT = 2'h3;

    localparam logic [3:0] START_BITS = 4'h1;
    localparam logic [3:0] STOP_BITS = 4'h1;

    localparam int BAUD_RATE [BAUD_COUNT] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600};

    // Serial port settings: fmt[2:0] baud[5:3] hs[7:6] addr[14:8] frame[17:16] csum[18] phy[21:20]
    typedef struct packed {
        logic [1:0] phy;
        logic spare_hi;
        logic csum;
        logic [1:0] frame;
        logic spare_lo;
        logic [6:0] addr;
        logic [1:0] hs;
        logic [2:0] baud;
        logic [2:0] fmt;
    } socfg_port_t;

    typedef struct packed {
        logic [3:0] copies;
        logic [3:0] lf_bot;
        logic [3:0] lf_top;
        logic [1:0] trig;
        logic page_adv;
        logic [1:0] id2;
        logic [1:0] id1;
        logic cn;
        logic dt;
        logic [2:0] layout;
    } socfg_prn_t;

    typedef struct packed {
        logic [3:0] data_bits;
        logic parity_en;
        logic parity_odd;
        logic check_byte;
        logic [BAUD_W-1:0] baud_div;
    } socfg_line_t;

endpackage : socfg_pkg

/* File: hdl/socfg_line.sv */
`timescale 1ns/1ps
module socfg_line (
    input wire logic aclk,
    input wire logic aresetn,
    input wire socfg_pkg::socfg_port_t cfg,
    input wire logic is_net,
    output socfg_pkg::socfg_line_t line
);
    localparam int BAUD_W = socfg_pkg::BAUD_W;
    socfg_pkg::socfg_line_t next_line;

    always_comb begin
        next_line = '0;
        next_line.data_bits = (cfg.frame == socfg_pkg::FRM_8N) ? 4'h8 : 4'h7;
        next_line.parity_en = (cfg.frame != socfg_pkg::FRM_8N);
        next_line.parity_odd = (cfg.frame == socfg_pkg::FRM_7O);
        // Network continuous records never carry the check byte
        next_line.check_byte = cfg.csum && !(is_net && cfg.fmt == socfg_pkg::FMT_CONT);
        next_line.baud_div = BAUD_W'(socfg_pkg::CLK_HZ / socfg_pkg::BAUD_RATE[cfg.baud]);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            line <= '0;
        end else begin
            line <= next_line;
        end
    end

endmodule : socfg_line

/* File: testbench/socfg_printer.sv */
`timescale 1ns/1ps
module socfg_printer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic print_req,
    input wire logic nv_write,
    output int prints,
    output int commits
);
    // Counts whole labels and commits; the bench judges totals, not timing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prints <= 0;
            commits <= 0;
        end else begin
            prints <= prints + int'(print_req);
            commits <= commits + int'(nv_write);
        end
    end
endmodule : socfg_printer

/* File: testbench/socfg_top_tb_top.sv */
`timescale 1ns/1ps
module socfg_top_tb_top;
    logic aclk = 0;
    logic aresetn = 0;
    logic [7:0] awaddr = 0;
    logic [7:0] araddr = 0;
    logic [31:0] wdata = 0;
    logic [31:0] rdata;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, phy3;
    logic [23:0] weight = 0;
    logic weight_stable = 0, print_key = 0, print_req, nv_write, mb_low_first;
    logic [3:0] copies_eff, fsb, fpb;
    socfg_pkg::socfg_line_t line1, line2, line3, line_net;
    int prints, commits, bad_count = 0, tests_run = 0, cyc = 0;
    socfg_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .weight(weight), .weight_stable(weight_stable),
        .print_key(print_key), .print_req(print_req), .nv_write(nv_write),
        .line1(line1), .line2(line2), .line3(line3), .line_net(line_net), .phy3(phy3),
        .mb_low_first(mb_low_first), .copies_eff(copies_eff),
        .frame_start_bits(fsb), .frame_stop_bits(fpb));
    socfg_printer prn (.aclk(aclk), .aresetn(aresetn), .print_req(print_req),
        .nv_write(nv_write), .prints(prints), .commits(commits));
    initial begin
        forever #2 aclk = ~aclk;
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            bad_count++;
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
            bad_count++;
        end
    endtask : chk
    // Offers address and data together, drops each as it is taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_d, w_d;
        aw_d = 0;
        w_d = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!(aw_d && w_d)) begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) begin
                aw_d = 1;
                awvalid <= 0;
            end
            if (wvalid && wready === 1'b1) begin
                w_d = 1;
                wvalid <= 0;
            end
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        chk(32'(bresp), 32'(er));
        bready <= 0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        @(posedge aclk);
        while (arready !== 1'b1) @(posedge aclk);
        arvalid <= 0;
        @(posedge aclk);
        while (rvalid !== 1'b1) @(posedge aclk);
        chk(rdata, ed);
        chk(32'(rresp), 32'(er));
        rready <= 0;
    endtask : rd
    // Exit code write; live outputs settle one cycle after the copy
    task automatic leave(input logic [31:0] code);
        wr(socfg_pkg::OFS_CTRL, code, 2'h0);
        repeat (2) @(posedge aclk);
    endtask : leave
    task automatic t_reset();
        rd(socfg_pkg::OFS_IF1, 32'h0, 2'h0);
        rd(socfg_pkg::OFS_PRN, 32'h00100001, 2'h0);
        rd(8'h40, 32'h0, 2'h2);
        chk(32'(line1.data_bits), 32'h8);
        chk(32'(line1.baud_div), 32'd208333);
        chk(32'(fsb), 32'h1);
        chk(32'(fpb), 32'h1);
    endtask : t_reset
    task automatic t_lines();
        int fr;
        for (int k = 0; k < 7; k++) begin
            fr = k % 3;
            wr(socfg_pkg::OFS_IF1, (k << 3) | (fr << 16) | ((k & 1) << 18) | 1, 2'h0);
            leave(2);
            chk(32'(line1.baud_div), socfg_pkg::CLK_HZ / socfg_pkg::BAUD_RATE[k]);
            chk(32'(line1.data_bits), (fr == 0) ? 8 : 7);
            chk(32'(line1.parity_en), 32'(fr != 0));
            chk(32'(line1.parity_odd), 32'(fr == 1));
            chk(32'(line1.check_byte), k & 1);
        end
        wr(socfg_pkg::OFS_IF1, 32'h00000039, 2'h2);
        rd(socfg_pkg::OFS_IF1, 32'h00000031, 2'h0);
    endtask : t_lines
    task automatic t_formats();
        wr(socfg_pkg::OFS_IF1, 32'h2, 2'h0);
        wr(socfg_pkg::OFS_IF2, 32'h2, 2'h2);
        wr(socfg_pkg::OFS_IF2, 32'h1, 2'h0);
        wr(socfg_pkg::OFS_IF3, 32'h1, 2'h0);
        wr(socfg_pkg::OFS_IF2, 32'h3, 2'h0);
        wr(socfg_pkg::OFS_IF1, 32'h3, 2'h2);
        wr(socfg_pkg::OFS_IF1, 32'h4, 2'h2);
        wr(socfg_pkg::OFS_IF1, 32'h00006302, 2'h0);
        wr(socfg_pkg::OFS_IF1, 32'h00006402, 2'h2);
        rd(socfg_pkg::OFS_IF1, 32'h00006302, 2'h0);
    endtask : t_formats
    task automatic t_modbus();
        wr(socfg_pkg::OFS_IF3, 32'h00100004, 2'h0);
        wr(socfg_pkg::OFS_IF2, 32'h00000083, 2'h0);
        wr(socfg_pkg::OFS_IF3, 32'h00000004, 2'h2);
        wr(socfg_pkg::OFS_IF1, 32'h00006382, 2'h2);
        wr(socfg_pkg::OFS_NET, 32'h00040001, 2'h0);
        leave(2);
        chk(32'(phy3), 32'h1);
        chk(32'(mb_low_first), 32'h0);
        chk(32'(line_net.check_byte), 32'h0);
        chk(32'(line2.data_bits), 32'h8);
        chk(32'(line3.parity_en), 32'h0);
        wr(socfg_pkg::OFS_IF3, 32'h00200005, 2'h0);
        wr(socfg_pkg::OFS_NET, 32'h00000006, 2'h2);
        wr(socfg_pkg::OFS_NET, 32'h00040004, 2'h0);
        leave(2);
        chk(32'(line_net.check_byte), 32'h1);
        chk(32'(phy3), 32'h2);
        chk(32'(mb_low_first), 32'h1);
    endtask : t_modbus
    task automatic press(input logic [23:0] w, input int exp);
        weight <= w;
        @(posedge aclk);
        print_key <= 1;
        @(posedge aclk);
        print_key <= 0;
        repeat (8) @(posedge aclk);
        chk(prints, exp);
    endtask : press
    task automatic t_print();
        wr(socfg_pkg::OFS_MINW, 32'd100, 2'h0);
        wr(socfg_pkg::OFS_PRN, 32'h0030077a, 2'h0);
        wr(socfg_pkg::OFS_PRN, 32'h0010a001, 2'h2);
        rd(socfg_pkg::OFS_PRN, 32'h0030077a, 2'h0);
        leave(2);
        chk(32'(copies_eff), 32'h3);
        weight_stable <= 1;
        weight <= 24'd50;
        repeat (20) @(posedge aclk);
        chk(prints, 0);
        weight <= 24'd200;
        repeat (20) @(posedge aclk);
        chk(prints, 1);
        weight <= 24'd50;
        repeat (5) @(posedge aclk);
        weight <= 24'd200;
        repeat (20) @(posedge aclk);
        chk(prints, 2);
        wr(socfg_pkg::OFS_PRN, 32'h00300801, 2'h0);
        leave(2);
        chk(32'(copies_eff), 32'h1);
        press(24'd300, 3);
        press(24'd300, 3);
        press(24'd310, 4);
        wr(socfg_pkg::OFS_PRN, 32'h00300001, 2'h0);
        leave(2);
        press(24'd310, 5);
        press(24'd50, 5);
    endtask : t_print
    task automatic t_exit();
        leave(1);
        chk(commits, 1);
        wr(socfg_pkg::OFS_IF1, 32'h0000632a, 2'h0);
        leave(3);
        rd(socfg_pkg::OFS_IF1, 32'h00006302, 2'h0);
        wr(socfg_pkg::OFS_CTRL, 32'h0, 2'h2);
        rd(socfg_pkg::OFS_STAT, 32'd10, 2'h0);
        rd(socfg_pkg::OFS_CTRL, 32'h1, 2'h0);
    endtask : t_exit
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        t_reset();
        t_lines();
        t_formats();
        t_modbus();
        t_print();
        t_exit();
        finish_test();
    end
endmodule : socfg_top_tb_top
